// [hw/qpc_device.sv]
`timescale 1ns/10ps
module qpc_device #(
   parameter int NV_WRITE_CYCLES = qpc_pkg::QPC_NV_WRITE_CYCLES,
   parameter logic [3:0] DEVICE_TYPE = qpc_pkg::QPC_TYPE_DEFAULT // Arbitrary value
) (
   input wire logic clk_in, // 200 MHz core clock
   input wire logic rst_in, // Async, active high
   qpc_link_if.device link, // Serial link
   input wire logic [1:0] strap_address_bits_in, // Address straps
   output logic [3:0][63:0] tap_select_out, // One-hot taps per pot
   output logic nv_write_pending_out // Save in progress
);
   import qpc_pkg::*;

   localparam int NVW = $clog2(NV_WRITE_CYCLES + 1);
   localparam int DLW = $clog2(QPC_WIPER_DELAY_CYCLES + 1);

   if (NV_WRITE_CYCLES < 1) begin : g_chk
      $error("NV_WRITE_CYCLES must be at least 1");
   end

   typedef enum logic [4:0] {
      QPC_RECALL = 5'h01,
      QPC_IDLE = 5'h02,
      QPC_RECV = 5'h04,
      QPC_STEP = 5'h08,
      QPC_IGNORE = 5'h10
   } qpc_dev_state_t;

   qpc_dev_state_t state_reg;
   logic [4:0] meta_reg;
   logic [4:0] sync_reg;
   logic sck_d_reg;
   logic cs_d_reg;
   logic [4:0] cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] instr_reg;
   logic [7:0] out_reg;
   logic so_oe_reg;
   logic [5:0] pend_reg;
   logic [3:0][5:0] wiper_reg;
   logic [3:0][3:0][5:0] preset_reg;
   logic nv_start_reg;
   logic nv_busy_reg;
   logic [NVW-1:0] nv_timer_reg;

   logic cs_n_s;
   logic sck_s;
   logic si_s;
   logic sck_rise;
   logic sck_fall;
   logic cs_rise;
   logic cs_fall;
   logic [7:0] byte_in;
   qpc_op_t op;
   logic [1:0] rsel;
   logic [1:0] psel;

   // Command legality; while a save runs only the status read is served
   function automatic logic cmd_ok(input logic [7:0] ins, input logic busy);
      logic ok;
      ok = 1'b0;
      unique case (ins[7:4])
         QPC_OP_READ_WIPER, QPC_OP_WRITE_WIPER, QPC_OP_STEP:
            ok = (ins[3:2] == QPC_SEL_ZERO); // R11 R14
         QPC_OP_READ_PRESET, QPC_OP_WRITE_PRESET,
         QPC_OP_PRESET_TO_WIPER, QPC_OP_WIPER_TO_PRESET:
            ok = 1'b1;
         QPC_OP_ALL_TO_WIPER, QPC_OP_ALL_TO_PRESET:
            ok = (ins[1:0] == QPC_SEL_ZERO); // R13
         QPC_OP_STATUS:
            ok = (ins[3:2] == QPC_SEL_ZERO) && (ins[1:0] == QPC_STATUS_POT); // R15
         default:
            ok = 1'b0;
      endcase
      return ok && (!busy || ins[7:4] == QPC_OP_STATUS);
   endfunction

   // Pins pass two flops before any use
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         meta_reg <= 5'h10;
         sync_reg <= 5'h10;
         sck_d_reg <= 1'b0;
         cs_d_reg <= 1'b1;
      end
      else
      begin
         meta_reg <= {link.cs_n, link.sck, link.si, strap_address_bits_in};
         sync_reg <= meta_reg;
         sck_d_reg <= sync_reg[3];
         cs_d_reg <= sync_reg[4];
      end
   end

   assign cs_n_s = sync_reg[4];
   assign sck_s = sync_reg[3];
   assign si_s = sync_reg[2];
   assign sck_rise = sck_s & ~sck_d_reg; // R21
   assign sck_fall = ~sck_s & sck_d_reg;
   assign cs_rise = cs_n_s & ~cs_d_reg;
   assign cs_fall = ~cs_n_s & cs_d_reg;
   assign byte_in = {shift_reg[6:0], si_s}; // R21
   assign op = qpc_op_t'(instr_reg[7:4]); // R04
   assign rsel = instr_reg[3:2];
   assign psel = instr_reg[1:0];

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_reg <= QPC_RECALL;
         cnt_reg <= 5'h00;
         shift_reg <= 8'h00;
         instr_reg <= 8'h00;
         out_reg <= 8'h00;
         so_oe_reg <= 1'b0;
         pend_reg <= QPC_PRESET_INIT;
         wiper_reg <= {4{QPC_PRESET_INIT}};
         preset_reg <= {16{QPC_PRESET_INIT}};
         nv_start_reg <= 1'b0;
      end
      else
      begin
         nv_start_reg <= 1'b0;
         unique case (state_reg)
            QPC_RECALL:
            begin
               for (int i = 0; i < 4; i++)
                  wiper_reg[i] <= preset_reg[i][0]; // R07
               state_reg <= QPC_IDLE;
            end
            QPC_IDLE:
            begin
               if (cs_fall)
               begin
                  state_reg <= QPC_RECV;
                  cnt_reg <= 5'h00;
               end
            end
            QPC_RECV:
            begin
               if (cs_rise)
               begin
                  state_reg <= QPC_IDLE;
                  so_oe_reg <= 1'b0;
                  // Two-byte commands act only on an exact byte count
                  if (cnt_reg == QPC_CNT_TWO)
                  begin
                     unique case (op)
                        QPC_OP_PRESET_TO_WIPER:
                           wiper_reg[psel] <= preset_reg[psel][rsel]; // R12 R17
                        QPC_OP_WIPER_TO_PRESET:
                        begin
                           preset_reg[psel][rsel] <= wiper_reg[psel]; // R12 R17
                           nv_start_reg <= 1'b1; // R09
                        end
                        QPC_OP_ALL_TO_WIPER:
                           for (int i = 0; i < 4; i++)
                              wiper_reg[i] <= preset_reg[i][rsel]; // R13
                        QPC_OP_ALL_TO_PRESET:
                        begin
                           for (int i = 0; i < 4; i++)
                              preset_reg[i][rsel] <= wiper_reg[i]; // R13
                           nv_start_reg <= 1'b1; // R09
                        end
                        default:
                           ;
                     endcase
                  end
                  if (cnt_reg == QPC_CNT_THREE && op == QPC_OP_WRITE_PRESET)
                  begin
                     preset_reg[psel][rsel] <= pend_reg; // R11 R05
                     nv_start_reg <= 1'b1; // R09
                  end
               end
               else if (sck_rise)
               begin
                  shift_reg <= byte_in;
                  if (cnt_reg != QPC_CNT_OVER)
                     cnt_reg <= cnt_reg + 5'h01;
                  if (cnt_reg == QPC_CNT_ADDR_LAST &&
                      (byte_in[7:4] != DEVICE_TYPE || byte_in[1:0] != sync_reg[1:0]))
                     state_reg <= QPC_IGNORE; // R01 R02
                  if (cnt_reg == QPC_CNT_INSTR_LAST)
                  begin
                     instr_reg <= byte_in; // R04
                     so_oe_reg <= 1'b0;
                     if (!cmd_ok(byte_in, nv_busy_reg))
                        state_reg <= QPC_IGNORE;
                     else if (byte_in[7:4] == QPC_OP_STEP)
                        state_reg <= QPC_STEP; // R14
                     else if (byte_in[7:4] == QPC_OP_READ_WIPER)
                     begin
                        out_reg <= {2'h0, wiper_reg[byte_in[1:0]]}; // R11 R16
                        so_oe_reg <= 1'b1;
                     end
                     else if (byte_in[7:4] == QPC_OP_READ_PRESET)
                     begin
                        out_reg <= {2'h0, preset_reg[byte_in[1:0]][byte_in[3:2]]}; // R05
                        so_oe_reg <= 1'b1;
                     end
                     else if (byte_in[7:4] == QPC_OP_STATUS)
                     begin
                        out_reg <= {7'h00, nv_busy_reg}; // R10 R15
                        so_oe_reg <= 1'b1;
                     end
                  end
                  if (cnt_reg == QPC_CNT_DATA_LAST)
                  begin
                     if (op == QPC_OP_WRITE_WIPER)
                        wiper_reg[psel] <= byte_in[5:0]; // R11 R16
                     pend_reg <= byte_in[5:0];
                  end
               end
               else if (sck_fall && cnt_reg > QPC_CNT_TWO && cnt_reg < QPC_CNT_THREE)
                  out_reg <= {out_reg[6:0], 1'b0}; // R21
            end
            QPC_STEP:
            begin
               if (cs_rise)
                  state_reg <= QPC_IDLE;
               else if (sck_rise)
               begin
                  if (si_s && wiper_reg[psel] != QPC_TAP_TOP)
                     wiper_reg[psel] <= wiper_reg[psel] + 6'h01; // R19 R20
                  else if (!si_s && wiper_reg[psel] != QPC_TAP_BOTTOM)
                     wiper_reg[psel] <= wiper_reg[psel] - 6'h01; // R19 R20
               end
            end
            QPC_IGNORE:
            begin
               if (cs_rise)
                  state_reg <= QPC_IDLE;
            end
            default:
               state_reg <= QPC_IDLE;
         endcase
      end
   end

   // Save timer: bounded by the longest allowed save time
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         nv_busy_reg <= 1'b0;
         nv_timer_reg <= '0;
      end
      else if (nv_start_reg)
      begin
         nv_busy_reg <= 1'b1; // R10
         nv_timer_reg <= '0;
      end
      else if (nv_busy_reg)
      begin
         if (nv_timer_reg == NVW'(NV_WRITE_CYCLES - 1))
            nv_busy_reg <= 1'b0; // R08
         else
            nv_timer_reg <= nv_timer_reg + NVW'(1);
      end
   end

   // Taps follow the wiper only after the response delay; a change
   // during the wait restarts nothing, the newest value is applied
   for (genvar p = 0; p < 4; p++) begin : g_pot
      logic [5:0] applied_reg;
      logic [DLW-1:0] dly_reg;
      always_ff @(posedge clk_in or posedge rst_in)
      begin
         if (rst_in)
         begin
            applied_reg <= QPC_PRESET_INIT;
            dly_reg <= '0;
            tap_select_out[p] <= 64'h0000000000000001;
         end
         else
         begin
            tap_select_out[p] <= 64'h0000000000000001 << applied_reg; // R06
            if (applied_reg == wiper_reg[p])
               dly_reg <= '0;
            else if (dly_reg == DLW'(QPC_WIPER_DELAY_CYCLES - 1))
            begin
               applied_reg <= wiper_reg[p]; // R18
               dly_reg <= '0;
            end
            else
               dly_reg <= dly_reg + DLW'(1);
         end
      end
   end

   assign link.so = out_reg[7];
   assign link.so_oe = so_oe_reg;
   assign nv_write_pending_out = nv_busy_reg;
endmodule

// [hw/qpc_pkg.sv]
// Contract
// R01 - First byte top nibble: device type, must match
// R02 - Low address bits must equal strap pins
// R03 - Master sends address bits 3:2 as zero
// R04 - Second byte: opcode, preset select, pot select
// R05 - Preset select binary value picks slot 0-3
// R06 - Four 6-bit wipers, each one-hot over 64 taps
// R07 - Power-up loads each wiper from slot zero
// R08 - Four presets per pot, save within 5ms
// R09 - Preset save starts when chip select rises
// R10 - Write-pending status bit high during save
// R11 - Opcodes read/write wiper and read/write preset
// R12 - Single transfers preset-to-wiper and wiper-to-preset
// R13 - Global transfers need pot select zero
// R14 - Step opcode with preset select zero
// R15 - Status read: opcode 0101, selectors 00/01
// R16 - Read/write/status commands are three bytes
// R17 - Transfers are two bytes, ended by chip select
// R18 - Wiper reaches taps after response delay
// R19 - Step: input high moves up, low down
// R20 - Stepping saturates at taps 0 and 63
// R21 - MSB first, sampled on rising clock edge
package qpc_pkg;
   // Arbitrary type code; both ends must be built with the same value
   localparam logic [3:0] QPC_TYPE_DEFAULT = 4'hA;
   typedef enum logic [3:0] {
      QPC_OP_ALL_TO_WIPER = 4'h1,
      QPC_OP_STEP = 4'h2,
      QPC_OP_STATUS = 4'h5,
      QPC_OP_ALL_TO_PRESET = 4'h8,
      QPC_OP_READ_WIPER = 4'h9,
      QPC_OP_WRITE_WIPER = 4'hA,
      QPC_OP_READ_PRESET = 4'hB,
      QPC_OP_WRITE_PRESET = 4'hC,
      QPC_OP_PRESET_TO_WIPER = 4'hD,
      QPC_OP_WIPER_TO_PRESET = 4'hE
   } qpc_op_t;
   localparam logic [4:0] QPC_CNT_ADDR_LAST = 5'h07;
   localparam logic [4:0] QPC_CNT_INSTR_LAST = 5'h0F;
   localparam logic [4:0] QPC_CNT_TWO = 5'h10;
   localparam logic [4:0] QPC_CNT_DATA_LAST = 5'h17;
   localparam logic [4:0] QPC_CNT_THREE = 5'h18;
   localparam logic [4:0] QPC_CNT_OVER = 5'h19;
   localparam logic [1:0] QPC_SEL_ZERO = 2'h0;
   localparam logic [1:0] QPC_STATUS_POT = 2'h1;
   localparam logic [5:0] QPC_PRESET_INIT = 6'h00;
   localparam logic [5:0] QPC_TAP_TOP = 6'h3F;
   localparam logic [5:0] QPC_TAP_BOTTOM = 6'h00;
   localparam int QPC_CLK_MHZ = 200;
   localparam int QPC_CLK_PERIOD_NS = 5;
   localparam int QPC_NV_WRITE_TIME_NS = 5000000;
   localparam int QPC_NV_WRITE_CYCLES = QPC_NV_WRITE_TIME_NS * QPC_CLK_MHZ / 1000;
   localparam int QPC_WIPER_DELAY_NS = 1000;
   localparam int QPC_WIPER_DELAY_CYCLES = QPC_WIPER_DELAY_NS * QPC_CLK_MHZ / 1000;
   localparam int QPC_SCK_PERIOD_NS = 80;
   localparam int QPC_SCK_HALF_CYCLES = QPC_SCK_PERIOD_NS / (2 * QPC_CLK_PERIOD_NS);
   localparam logic [31:0] QPC_CTRL_OFS = 32'h00000000;
   localparam logic [31:0] QPC_STATUS_OFS = 32'h00000004;
   localparam int QPC_CTRL_INSTR_LSB = 0;
   localparam int QPC_CTRL_DATA_LSB = 8;
   localparam int QPC_CTRL_TARGET_LSB = 16;
   localparam int QPC_CTRL_STEPS_LSB = 24;
   localparam int QPC_STAT_BUSY_BIT = 0;
   localparam int QPC_STAT_DONE_BIT = 1;
   localparam int QPC_STAT_RX_LSB = 8;
   localparam logic [31:0] QPC_CTRL_RESET = 32'h00000000;

   // Serial clocks per command: three bytes, two bytes, or 16 plus steps
   function automatic logic [8:0] qpc_cmd_bits(input logic [3:0] op,
                                                input logic [7:0] steps);
      logic [8:0] n;
      n = 9'h010;
      if (op == QPC_OP_READ_WIPER || op == QPC_OP_WRITE_WIPER || op == QPC_OP_STATUS ||
          op == QPC_OP_READ_PRESET || op == QPC_OP_WRITE_PRESET)
         n = 9'h018;
      else if (op == QPC_OP_STEP)
         n = 9'h010 + {1'b0, steps};
      return n;
   endfunction
endpackage

// [hw/qpc_link_if.sv]
`timescale 1ns/10ps
interface qpc_link_if;
   logic cs_n;
   logic sck;
   logic si;
   logic so;
   logic so_oe;
   modport master (output cs_n, output sck, output si, input so);
   modport device (input cs_n, input sck, input si, output so, output so_oe);
endinterface

// [hw/qpc_master.sv]
`timescale 1ns/10ps
module qpc_master #(
   parameter int SCK_HALF = qpc_pkg::QPC_SCK_HALF_CYCLES,
   parameter logic [3:0] DEVICE_TYPE = qpc_pkg::QPC_TYPE_DEFAULT // Arbitrary value
) (
   input wire logic clk_in, // 200 MHz clock, also hclk
   input wire logic rst_in, // Async, active high
   input wire logic hsel_in, // AHB select
   input wire logic [31:0] haddr_in, // AHB address
   input wire logic [1:0] htrans_in, // AHB transfer type
   input wire logic hwrite_in, // AHB write
   input wire logic [2:0] hsize_in, // AHB size, word only
   input wire logic [31:0] hwdata_in, // AHB write data
   input wire logic hready_in, // AHB bus ready
   output logic hreadyout_out, // AHB slave ready
   output logic hresp_out, // AHB response
   output logic [31:0] hrdata_out, // AHB read data
   qpc_link_if.master link // Serial link
);
   import qpc_pkg::*;

   localparam int TW = $clog2(SCK_HALF + 1);

   // Device needs about three cycles to see an edge and update its output
   if (SCK_HALF < 6) begin : g_chk
      $error("SCK_HALF must be at least 6");
   end

   typedef enum logic [5:0] {
      QPC_H_IDLE = 6'h01,
      QPC_H_LEAD = 6'h02,
      QPC_H_HIGH = 6'h04,
      QPC_H_LOW = 6'h08,
      QPC_H_TAIL = 6'h10,
      QPC_H_GAP = 6'h20
   } qpc_host_state_t;

   qpc_host_state_t state_reg;
   logic [31:0] addr_reg;
   logic wr_pend_reg;
   logic [31:0] hrdata_reg;
   logic [31:0] ctrl_reg;
   logic busy_reg;
   logic done_reg;
   logic [7:0] rx_reg;
   logic [23:0] tx_reg;
   logic [8:0] nbits_reg;
   logic [8:0] idx_reg;
   logic [TW-1:0] tmr_reg;
   logic cs_n_reg;
   logic sck_reg;
   logic si_reg;
   logic so_meta_reg;
   logic so_sync_reg;
   logic start;
   logic half_done;
   logic sample;

   // Step bits repeat the direction held in data bit 0
   function automatic logic tx_bit(input logic [23:0] tx, input logic [8:0] i);
      logic b;
      b = tx[0];
      if (i < 9'h018)
         b = tx[5'(9'h017 - i)]; // R21
      return b;
   endfunction

   assign start = wr_pend_reg && addr_reg == QPC_CTRL_OFS && !busy_reg;
   assign half_done = (tmr_reg == TW'(SCK_HALF - 1));
   assign sample = idx_reg >= 9'h010 && idx_reg < 9'h018;

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         addr_reg <= 32'h00000000;
         wr_pend_reg <= 1'b0;
         hrdata_reg <= 32'h00000000;
         ctrl_reg <= QPC_CTRL_RESET;
      end
      else
      begin
         wr_pend_reg <= hsel_in && hready_in && htrans_in[1] && hwrite_in;
         if (hsel_in && hready_in && htrans_in[1])
         begin
            addr_reg <= haddr_in;
            hrdata_reg <= 32'h00000000;
            if (haddr_in == QPC_CTRL_OFS)
               hrdata_reg <= ctrl_reg;
            else if (haddr_in == QPC_STATUS_OFS)
            begin
               hrdata_reg[QPC_STAT_BUSY_BIT] <= busy_reg;
               hrdata_reg[QPC_STAT_DONE_BIT] <= done_reg;
               hrdata_reg[QPC_STAT_RX_LSB +: 8] <= rx_reg;
            end
         end
         if (start)
            ctrl_reg <= hwdata_in;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         so_meta_reg <= 1'b0;
         so_sync_reg <= 1'b0;
      end
      else
      begin
         so_meta_reg <= link.so;
         so_sync_reg <= so_meta_reg;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_reg <= QPC_H_IDLE;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         rx_reg <= 8'h00;
         tx_reg <= 24'h000000;
         nbits_reg <= 9'h000;
         idx_reg <= 9'h000;
         tmr_reg <= '0;
         cs_n_reg <= 1'b1;
         sck_reg <= 1'b0;
         si_reg <= 1'b0;
      end
      else
      begin
         tmr_reg <= half_done ? '0 : tmr_reg + TW'(1);
         unique case (state_reg)
            QPC_H_IDLE:
            begin
               tmr_reg <= '0;
               if (start)
               begin
                  // R01 R03 R04
                  tx_reg <= {DEVICE_TYPE, 2'h0, hwdata_in[QPC_CTRL_TARGET_LSB +: 2],
                             hwdata_in[QPC_CTRL_INSTR_LSB +: 8],
                             ((hwdata_in[QPC_CTRL_INSTR_LSB + 4 +: 4] == QPC_OP_STEP) ?
                              {8{hwdata_in[QPC_CTRL_DATA_LSB]}} :
                              hwdata_in[QPC_CTRL_DATA_LSB +: 8])}; // R19
                  nbits_reg <= qpc_cmd_bits(hwdata_in[QPC_CTRL_INSTR_LSB + 4 +: 4],
                                            hwdata_in[QPC_CTRL_STEPS_LSB +: 8]); // R16 R17
                  idx_reg <= 9'h000;
                  cs_n_reg <= 1'b0;
                  si_reg <= DEVICE_TYPE[3]; // R21
                  busy_reg <= 1'b1;
                  done_reg <= 1'b0;
                  state_reg <= QPC_H_LEAD;
               end
            end
            QPC_H_LEAD, QPC_H_LOW:
            begin
               if (half_done)
               begin
                  sck_reg <= 1'b1;
                  if (sample)
                     rx_reg <= {rx_reg[6:0], so_sync_reg}; // R21
                  state_reg <= QPC_H_HIGH;
               end
            end
            QPC_H_HIGH:
            begin
               if (half_done)
               begin
                  sck_reg <= 1'b0;
                  if (idx_reg == nbits_reg - 9'h001)
                     state_reg <= QPC_H_TAIL;
                  else
                  begin
                     idx_reg <= idx_reg + 9'h001;
                     si_reg <= tx_bit(tx_reg, idx_reg + 9'h001); // R19
                     state_reg <= QPC_H_LOW;
                  end
               end
            end
            QPC_H_TAIL:
            begin
               if (half_done)
               begin
                  cs_n_reg <= 1'b1; // R17
                  state_reg <= QPC_H_GAP;
               end
            end
            QPC_H_GAP:
            begin
               if (half_done)
               begin
                  busy_reg <= 1'b0;
                  done_reg <= 1'b1;
                  state_reg <= QPC_H_IDLE;
               end
            end
            default:
               state_reg <= QPC_H_IDLE;
         endcase
      end
   end

   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;
   assign hrdata_out = hrdata_reg;
   assign link.cs_n = cs_n_reg;
   assign link.sck = sck_reg;
   assign link.si = si_reg;
endmodule

// [tb/qpc_link_chk.sv]
`timescale 1ns/10ps
module qpc_link_chk
   import qpc_pkg::*;
#(
   parameter logic [3:0] DEVICE_TYPE = QPC_TYPE_DEFAULT
) (
   input wire logic clk_in, // Clock
   input wire logic rst_in, // Reset
   input wire logic cs_n_in, // Select
   input wire logic sck_in, // Serial clock
   input wire logic si_in, // To device
   input wire logic so_oe_in // Device drives
);
   logic sck_q;
   logic [8:0] cnt;
   logic [7:0] sh;
   logic [7:0] byte0;
   logic [7:0] byte1;
   logic rise;
   assign rise = sck_in & ~sck_q;
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         sck_q <= 1'b0;
      else
         sck_q <= sck_in;
   end
   // Count restarts with every frame
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         cnt <= 9'h000;
      else if (cs_n_in)
         cnt <= 9'h000;
      else if (rise)
         cnt <= cnt + 9'h001;
   end
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         sh <= 8'h00;
         byte0 <= 8'h00;
         byte1 <= 8'h00;
      end
      else if (rise)
      begin
         sh <= {sh[6:0], si_in};
         if (cnt == 9'h007)
            byte0 <= {sh[6:0], si_in};
         if (cnt == 9'h00F)
            byte1 <= {sh[6:0], si_in};
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence s_high; sck_in [*8] ##1 !sck_in; endsequence
   sequence s_hold; $stable(si_in) [*8]; endsequence
   property p_idle; cs_n_in |-> !sck_in; endproperty
   property p_high; $rose(sck_in) |-> s_high; endproperty
   property p_si; $rose(sck_in) |-> s_hold; endproperty
   property p_type; $rose(cs_n_in) |-> byte0[7:2] == {DEVICE_TYPE, 2'h0}; endproperty
   property p_len;
      $rose(cs_n_in) |-> (byte1[7:4] inside {4'h5, 4'h9, 4'hA, 4'hB, 4'hC} ? cnt == 9'h018 :
         (byte1[7:4] == 4'h2 ? cnt >= 9'h010 : cnt == 9'h010));
   endproperty
   property p_oe; $rose(so_oe_in) |-> cnt == 9'h010 && byte1[7:4] inside {4'h5, 4'h9, 4'hB};
   endproperty
   property p_oe_end; $rose(cs_n_in) |-> ##[0:4] !so_oe_in; endproperty
   property p_gap; $rose(cs_n_in) |-> cs_n_in [*8]; endproperty
   a_idle: assert property (p_idle) else $error("clock not idle");
   a_high: assert property (p_high) else $error("bad high time");
   a_si: assert property (p_si) else $error("data moved");
   a_type: assert property (p_type) else $error("bad first byte");
   a_len: assert property (p_len) else $error("bad length");
   a_oe: assert property (p_oe) else $error("bad drive start");
   a_oe_end: assert property (p_oe_end) else $error("drive held");
   a_gap: assert property (p_gap) else $error("short gap");
endmodule

// [tb/testbench.sv]
`timescale 1ns/10ps
module testbench;
   import qpc_pkg::*;
   localparam int NV = 1000;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic hresp;
   logic [31:0] hrdata;
   logic [3:0][63:0] taps;
   logic pending;
   logic [31:0] rd;
   int fail_count = 0;
   int comparisons = 0;
   qpc_link_if link ();
   qpc_master i_qpc_master (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
      .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp),
      .hrdata_out(hrdata), .link(link.master));
   qpc_device #(.NV_WRITE_CYCLES(NV)) i_qpc_device (.clk_in(clk_in), .rst_in(rst_in),
      .link(link.device), .strap_address_bits_in(2'h1), .tap_select_out(taps),
      .nv_write_pending_out(pending));
   qpc_link_chk i_qpc_link_chk (.clk_in(clk_in), .rst_in(rst_in), .cs_n_in(link.cs_n),
      .sck_in(link.sck), .si_in(link.si), .so_oe_in(link.so_oe));
   always #2.5 clk_in = ~clk_in;
   task automatic check(input string s, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", s, exp, seen);
         fail_count++;
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge clk_in);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do
         @(posedge clk_in);
      while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do
         @(posedge clk_in);
      while (hready !== 1'b1);
      rd = hrdata;
   endtask
   // Polls until the serial frame is over; the watchdog bounds a hang
   task automatic cmd(input logic [7:0] ins, input logic [7:0] dat, input logic [7:0] n);
      ahb(1'b1, QPC_CTRL_OFS, {n, 6'h00, 2'h1, dat, ins});
      rd = 32'h1;
      while (rd[QPC_STAT_BUSY_BIT] !== 1'b0)
         ahb(1'b0, QPC_STATUS_OFS, 32'h0);
   endtask
   task automatic tap(input int p, input int v);
      repeat (210)
         @(posedge clk_in);
      check("tap", taps[p], 64'h1 << v);
   endtask
   task automatic save();
      realtime t0;
      wait (pending === 1'b1);
      t0 = $realtime;
      check("cs at save", link.cs_n, 1'b1);
      cmd(8'h51, 8'h00, 8'h00);
      check("pending bit", rd[15:8], 8'h01);
      wait (pending === 1'b0);
      check("save time", ($realtime - t0) <= NV * 5.0, 1'b1);
   endtask
   initial
   begin
      repeat (12)
         @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (4)
         @(posedge clk_in);
      for (int p = 0; p < 4; p++)
         check("reset tap", taps[p], 64'h1);
      ahb(1'b0, 32'h00000010, 32'h0);
      check("unmapped", rd, 32'h0);
      check("hresp", hresp, 1'b0);
      $display("test reset ended");
      cmd(8'hA2, 8'h2A, 8'h00);
      check("early tap", taps[2], 64'h1);
      tap(2, 42);
      cmd(8'h92, 8'h00, 8'h00);
      check("wiper read", rd[15:8], 8'h2A);
      check("done bit", rd[QPC_STAT_DONE_BIT], 1'b1);
      ahb(1'b0, QPC_CTRL_OFS, 32'h0);
      check("ctrl", rd, 32'h00010092);
      ahb(1'b1, QPC_CTRL_OFS, 32'h000205A2);
      cmd(8'h51, 8'h00, 8'h00);
      tap(2, 42);
      $display("test wiper ended");
      cmd(8'hCD, 8'h15, 8'h00);
      save();
      cmd(8'hBD, 8'h00, 8'h00);
      check("preset read", rd[15:8], 8'h15);
      cmd(8'hDD, 8'h00, 8'h00);
      tap(1, 21);
      $display("test preset ended");
      cmd(8'h88, 8'h00, 8'h00);
      save();
      cmd(8'hA1, 8'h3F, 8'h00);
      cmd(8'h18, 8'h00, 8'h00);
      tap(1, 21);
      $display("test global ended");
      cmd(8'hA3, 8'h3E, 8'h00);
      cmd(8'h23, 8'h01, 8'h03);
      tap(3, 63);
      cmd(8'h23, 8'h00, 8'h05);
      tap(3, 58);
      $display("test step ended");
      cmd(8'hE7, 8'h00, 8'h00);
      // Refused while the save runs, so the wiper keeps 58
      cmd(8'hA3, 8'h00, 8'h00);
      save();
      cmd(8'hB7, 8'h00, 8'h00);
      check("wiper to preset", rd[15:8], 8'h3A);
      tap(3, 58);
      $display("test save ended");
      end_sim();
   end
   initial
   begin
      #300000;
      fail_count++;
      $display("watchdog expired");
      end_sim();
   end
endmodule
